// ==== bench/lducr_chk.sv ====
`timescale 1ns/1ps
module lducr_chk (
    // clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // register port
    input wire lducr_pkg::lducr_req_t        req,
    input wire logic [lducr_pkg::DATA_W-1:0] rdata,
    input wire logic                         rvalid,
    input wire logic                         addr_err,
    // images and steering
    input wire lducr_pkg::lducr_cfg_spread_t cfg_spread,
    input wire lducr_pkg::lducr_cfg_short_t  cfg_short,
    input wire lducr_pkg::lducr_steer_t      steer
);
    import lducr_pkg::*;
    logic hit;
    // offset lands on one of the two registers
    assign hit = req.addr == OFS_SPREAD_SLOPE || req.addr == OFS_SHORT_DETECT;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // register port answers
    a_rd_answer: assert property (req.rd_en |=> rvalid)
        else $error("read not answered");
    a_rd_spread: assert property (req.rd_en && req.addr == OFS_SPREAD_SLOPE |=>
        rdata == $past(cfg_spread)) else $error("spread readback wrong");
    a_rd_short: assert property (req.rd_en && req.addr == OFS_SHORT_DETECT |=>
        rdata == $past(cfg_short)) else $error("short readback wrong");
    a_unmapped_err: assert property ((req.rd_en || req.wr_en) && !hit |=> addr_err)
        else $error("unmapped access not flagged");
    a_wr_spread: assert property (req.wr_en && req.addr == OFS_SPREAD_SLOPE |=>
        cfg_spread == $past(req.wdata)) else $error("spread write lost");
    a_wr_short: assert property (req.wr_en && req.addr == OFS_SHORT_DETECT |=>
        cfg_short == $past(req.wdata)) else $error("short write lost");
    // steering follows the stored images
    // steering lags one edge; the first edge after reset still shows zero, so it is skipped
    a_steer_src: assert property (!$past(rst) |->
        steer.brightness_from_reg == ($past(cfg_spread.brightness_source_sel) == BRT_SRC_REG))
        else $error("source wrong");
    a_steer_fault: assert property (!$past(rst) |->
        steer.string_short_fault_en == ~$past(cfg_short[3:0])) else $error("fault enables wrong");
    a_steer_dither: assert property (!$past(rst) |-> steer.dither_bits ==
        ($past(cfg_spread.dither_select) > DITHER_MAX_BITS ? DITHER_MAX_BITS
        : $past(cfg_spread.dither_select))) else $error("dither depth wrong");
    a_steer_shape: assert property (!$past(rst) |->
        steer.slope_shape == $past(cfg_spread.smooth_sloping_en)) else $error("shape wrong");
    a_steer_gnd: assert property (!$past(rst) |->
        steer.ground_short_detect_en == $past(cfg_short.ground_short_detect_en))
        else $error("ground detect wrong");
    // main scenarios
    c_wr_spread: cover property (req.wr_en && req.addr == OFS_SPREAD_SLOPE);
    c_unmapped: cover property (addr_err);
    c_rd_reset: cover property (rvalid && rdata == RST_SHORT_DETECT);
endmodule : lducr_chk

bind lducr_user_config_regs lducr_chk u_chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .addr_err(addr_err), .cfg_spread(cfg_spread), .cfg_short(cfg_short),
    .steer(steer));

// ==== bench/lducr_host.sv ====
`timescale 1ns/1ps
module lducr_host (
    // clock
    input  wire logic                         clk,
    // request towards the register bank
    output lducr_pkg::lducr_req_t             req,
    // answer
    input  wire logic [lducr_pkg::DATA_W-1:0] rdata,
    input  wire logic                         rvalid,
    input  wire logic                         addr_err
);
    import lducr_pkg::*;
    initial req = '0;
    // one-cycle write strobe; reserved bits 7-4 of the short register forced low
    task automatic wr(input logic [7:0] a, input logic [15:0] x);
        logic [15:0] v;
        v = (a == OFS_SHORT_DETECT) ? (x & 16'hff0f) : x;
        @(negedge clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: v};
        @(negedge clk);
        req <= '0;
    endtask : wr
    // answer stands one cycle, so it is taken at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [15:0] x, output logic v, output logic e);
        @(negedge clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        req <= '0;
        x = rdata;
        v = rvalid;
        e = addr_err;
    endtask : rd
endmodule : lducr_host

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import lducr_pkg::*;
    logic              clk;
    logic              rst;
    lducr_req_t        req;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              addr_err;
    lducr_cfg_spread_t cfg_spread;
    lducr_cfg_short_t  cfg_short;
    lducr_steer_t      steer;
    logic [15:0]       d;
    logic              v;
    logic              e;
    int                s;
    int                c;
    int num_errors = 0;
    int compares = 0;
    int ms_tab[8] = '{0, 1, 2, 50, 100, 200, 300, 500};
    int hz_tab[4] = '{200, 500, 800, 1200};
    int pm_tab[4] = '{33, 43, 53, 72};
    // one kilohertz of clock per millisecond keeps slope counts readable
    lducr_user_config_regs #(.CLK_KHZ(1), .SMOOTH_STRETCH(2)) dut (.clk(clk), .rst(rst),
        .req(req), .rdata(rdata), .rvalid(rvalid), .addr_err(addr_err),
        .cfg_spread(cfg_spread), .cfg_short(cfg_short), .steer(steer));
    lducr_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid), .addr_err(addr_err));
    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    // steering settles one rising edge after the write is taken
    task automatic wrs(input logic [7:0] a, input logic [15:0] x);
        host.wr(a, x);
        repeat (2) @(negedge clk);
    endtask : wrs
    task automatic rdc(input logic [7:0] a, input logic [15:0] x, input logic ex);
        host.rd(a, d, v, e);
        chk(v, 1);
        chk(d, x);
        chk(e, ex);
    endtask : rdc
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        rdc(OFS_SPREAD_SLOPE, 16'h08a3, 1'b0);
        rdc(OFS_SHORT_DETECT, 16'h0100, 1'b0);
        chk(steer.slope_cycles, 400);
        rdc(8'h08, 16'h0000, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wrs(OFS_SPREAD_SLOPE, 16'((i * 16'h1500) | ((i & 1) << 14)));
            chk(steer.spread_rate_hz, hz_tab[i]);
            chk(steer.spread_range_permille, pm_tab[i]);
            chk(steer.brightness_from_reg, i == 2);
            chk(steer.pseudo_spread_en, i & 1);
        end
        for (int i = 0; i < 16; i++) begin
            s = i / 8;
            c = i % 8;
            if (s == 1 && c inside {1, 2}) continue;
            wrs(OFS_SPREAD_SLOPE, 16'((c << 5) | (c << 2) | (s << 1)));
            chk(steer.slope_combo_warn, 0);
            chk(steer.slope_enabled, c != 0);
            if (c != 0) chk(steer.slope_cycles, ms_tab[c] * (s + 1));
            chk(steer.slope_shape, s);
            chk(steer.dither_bits, (c > 4) ? 4 : c);
        end
        wrs(OFS_SPREAD_SLOPE, 16'hffff);
        rdc(OFS_SPREAD_SLOPE, 16'hffff, 1'b0);
        chk(steer.brightness_from_reg, 0);
        for (int i = 0; i < 16; i++) begin
            wrs(OFS_SHORT_DETECT, 16'(((i & 1) << 8) | i));
            chk(steer.string_short_fault_en, ~i & 4'hf);
            chk(steer.ground_short_detect_en, i & 1);
        end
        wrs(8'h20, 16'h1234);
        rdc(OFS_SHORT_DETECT, 16'h010f, 1'b0);
        // second reset in mid-run
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        rdc(OFS_SHORT_DETECT, 16'h0100, 1'b0);
        summarize();
    end
    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule : tb

// ==== core/lducr_user_config_regs.sv ====
`timescale 1ns/1ps
// Operation
// - bit 14 enables pseudo-random spread modulation
// - bits 13-12 select 200/500/800/1200 Hz rate
// - bits 11-10 select spread range, reset 5.3%
// - bits 9-8 pick PWM pin or brightness register
// - bits 7-5 select slope duration, reset 200ms
// - smooth sloping lengthens duration, adds smoothing
// - bits 4-2 select dither depth 0 to 4
// - bit 1 selects smooth sloping, reset 1
// - second register bit 8 enables ground-short detect
// - bits 3-0 disable string 4..1 short fault
// - smooth sloping gives S-shaped transition curve
module lducr_user_config_regs #(
    parameter int CLK_KHZ       = lducr_pkg::CLK_FREQ_KHZ,
    parameter int SMOOTH_STRETCH = 2
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // register access from the serial interface engine
    input  wire lducr_pkg::lducr_req_t     req,
    output logic [lducr_pkg::DATA_W-1:0]   rdata,
    output logic                           rvalid,
    output logic                           addr_err,
    // raw register images
    output lducr_pkg::lducr_cfg_spread_t   cfg_spread,
    output lducr_pkg::lducr_cfg_short_t    cfg_short,
    // decoded steering
    output lducr_pkg::lducr_steer_t        steer
);
    import lducr_pkg::*;

    // slope duration in ms for a code, linear mode
    function automatic int slope_ms(input logic [2:0] code);
        unique case (code)
            3'h0: slope_ms = 0;
            3'h1: slope_ms = SLOPE_MS_1;
            3'h2: slope_ms = SLOPE_MS_2;
            3'h3: slope_ms = SLOPE_MS_3;
            3'h4: slope_ms = SLOPE_MS_4;
            3'h5: slope_ms = SLOPE_MS_5;
            3'h6: slope_ms = SLOPE_MS_6;
            3'h7: slope_ms = SLOPE_MS_7;
        endcase
    endfunction : slope_ms

    // spread modulation rate in Hz for a code
    function automatic int spread_hz(input logic [1:0] code);
        unique case (code)
            2'h0: spread_hz = SPREAD_HZ_0;
            2'h1: spread_hz = SPREAD_HZ_1;
            2'h2: spread_hz = SPREAD_HZ_2;
            2'h3: spread_hz = SPREAD_HZ_3;
        endcase
    endfunction : spread_hz

    // spread range in tenths of a percent for a code
    function automatic int spread_permille(input logic [1:0] code);
        unique case (code)
            2'h0: spread_permille = RANGE_PERMILLE_0;
            2'h1: spread_permille = RANGE_PERMILLE_1;
            2'h2: spread_permille = RANGE_PERMILLE_2;
            2'h3: spread_permille = RANGE_PERMILLE_3;
        endcase
    endfunction : spread_permille

    // which register an offset lands on; reads and writes share it
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_SPREAD,
        SEL_SHORT
    } lducr_sel_t;

    function automatic lducr_sel_t addr_sel(input logic [ADDR_W-1:0] addr);
        if (addr == OFS_SPREAD_SLOPE) begin
            addr_sel = SEL_SPREAD;
        end else if (addr == OFS_SHORT_DETECT) begin
            addr_sel = SEL_SHORT;
        end else begin
            addr_sel = SEL_NONE;
        end
    endfunction : addr_sel

    // register images and read port state
    lducr_cfg_spread_t     spread_q;
    lducr_cfg_spread_t     spread_d;
    lducr_cfg_short_t      short_q;
    lducr_cfg_short_t      short_d;
    logic [DATA_W-1:0]     rdata_q;
    logic [DATA_W-1:0]     rdata_d;
    logic                  rvalid_q;
    logic                  rvalid_d;
    logic                  err_q;
    logic                  err_d;
    lducr_steer_t          steer_q;
    lducr_steer_t          steer_d;
    lducr_sel_t            req_sel;

    // address decode shared by reads and writes
    assign req_sel = addr_sel(req.addr);

    // register writes: every bit stored as written, reserved ones too
    always_comb begin
        spread_d = spread_q;
        short_d  = short_q;
        if (req.wr_en && (req_sel == SEL_SPREAD)) begin
            spread_d = lducr_cfg_spread_t'(req.wdata);
        end
        // reserved bits are kept, not forced; zero is the host's duty
        if (req.wr_en && (req_sel == SEL_SHORT)) begin
            short_d = lducr_cfg_short_t'(req.wdata);
        end
    end

    // read port: data one cycle after the strobe, unmapped reads zero
    always_comb begin
        rdata_d  = '0;
        rvalid_d = req.rd_en;
        err_d    = (req.rd_en || req.wr_en) && (req_sel == SEL_NONE);
        if (req.rd_en) begin
            unique case (req_sel)
                SEL_SPREAD: rdata_d = DATA_W'(spread_q);
                SEL_SHORT:  rdata_d = DATA_W'(short_q);
                SEL_NONE:   rdata_d = '0;
                default:    rdata_d = '0;
            endcase
        end
    end

    // decode of the stored fields towards the engines
    always_comb begin
        int ms;
        int cyc;
        ms  = 0;
        cyc = 0;
        steer_d = '0;
        steer_d.pseudo_spread_en = spread_q.pseudo_spread_en;
        steer_d.spread_rate_hz =
            11'(spread_hz(spread_q.spread_modulation_rate));
        steer_d.spread_range_permille =
            7'(spread_permille(spread_q.spread_range));
        // reserved source codes fall back to the PWM pin
        steer_d.brightness_from_reg =
            (spread_q.brightness_source_sel == BRT_SRC_REG);
        ms = slope_ms(spread_q.slope_select);
        if (spread_q.smooth_sloping_en) begin
            ms = ms * SMOOTH_STRETCH;
        end
        cyc = ms * CLK_KHZ;
        steer_d.slope_cycles  = 32'(cyc);
        steer_d.slope_enabled = (spread_q.slope_select != SLOPE_CODE_OFF);
        steer_d.slope_shape   = spread_q.smooth_sloping_en
                                ? SHAPE_S_CURVE : SHAPE_LINEAR;
        // codes above four are undefined; clamp rather than overrun the engine
        steer_d.dither_bits = (spread_q.dither_select > DITHER_MAX_BITS)
                              ? DITHER_MAX_BITS : spread_q.dither_select;
        steer_d.ground_short_detect_en = short_q.ground_short_detect_en;
        steer_d.string_short_fault_en = ~{short_q.string4_short_fault_off,
                                          short_q.string3_short_fault_off,
                                          short_q.string2_short_fault_off,
                                          short_q.string1_short_fault_off};
        // flags the discouraged short-slope with smooth-slope pairing
        steer_d.slope_combo_warn = spread_q.smooth_sloping_en
            && (spread_q.slope_select != SLOPE_CODE_OFF)
            && (spread_q.slope_select <= SLOPE_CODE_2MS);
    end

    // register images; synchronous reset to their power-up values
    always_ff @(posedge clk) begin
        if (rst) begin
            spread_q <= lducr_cfg_spread_t'(RST_SPREAD_SLOPE);
            short_q  <= lducr_cfg_short_t'(RST_SHORT_DETECT);
        end else begin
            spread_q <= spread_d;
            short_q  <= short_d;
        end
    end

    // read port pulses, cleared by reset
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
            err_q    <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            err_q    <= err_d;
        end
    end

    // steering held at zero in reset so the engines stay idle until it ends
    always_ff @(posedge clk) begin
        if (rst) begin
            steer_q <= '0;
        end else begin
            steer_q <= steer_d;
        end
    end

    // outputs straight from flip-flops
    assign rdata      = rdata_q;
    assign rvalid     = rvalid_q;
    assign addr_err   = err_q;
    assign cfg_spread = spread_q;
    assign cfg_short  = short_q;
    assign steer      = steer_q;

endmodule : lducr_user_config_regs

// ==== include/lducr_pkg.sv ====
package lducr_pkg;

    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register offsets, as seen by the serial interface engine
    localparam logic [ADDR_W-1:0] OFS_SPREAD_SLOPE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SHORT_DETECT = 8'h06;

    // reset values
    localparam logic [DATA_W-1:0] RST_SPREAD_SLOPE = 16'h08a3;
    localparam logic [DATA_W-1:0] RST_SHORT_DETECT = 16'h0100;

    // clock rate, used to turn slope times into cycle counts
    localparam int CLK_FREQ_KHZ = 50000;

    // timing and rate tables
    localparam int SLOPE_MS_1 = 1;
    localparam int SLOPE_MS_2 = 2;
    localparam int SLOPE_MS_3 = 50;
    localparam int SLOPE_MS_4 = 100;
    localparam int SLOPE_MS_5 = 200;
    localparam int SLOPE_MS_6 = 300;
    localparam int SLOPE_MS_7 = 500;
    localparam int SPREAD_HZ_0 = 200;
    localparam int SPREAD_HZ_1 = 500;
    localparam int SPREAD_HZ_2 = 800;
    localparam int SPREAD_HZ_3 = 1200;
    // spread range in tenths of a percent
    localparam int RANGE_PERMILLE_0 = 33;
    localparam int RANGE_PERMILLE_1 = 43;
    localparam int RANGE_PERMILLE_2 = 53;
    localparam int RANGE_PERMILLE_3 = 72;
    localparam logic [2:0] DITHER_MAX_BITS = 3'h4;
    localparam logic [2:0] SLOPE_CODE_OFF  = 3'h0;
    localparam logic [2:0] SLOPE_CODE_2MS  = 3'h2;

    // brightness source codes
    typedef enum logic [1:0] {
        BRT_SRC_PWM  = 2'h0,
        BRT_SRC_RSV1 = 2'h1,
        BRT_SRC_REG  = 2'h2,
        BRT_SRC_RSV3 = 2'h3
    } lducr_brt_src_t;

    // slope curve shape
    typedef enum logic {
        SHAPE_LINEAR  = 1'b0,
        SHAPE_S_CURVE = 1'b1
    } lducr_shape_t;

    // layout of the spread and slope register, msb first
    typedef struct packed {
        logic           rsvd15;
        logic           pseudo_spread_en;
        logic [1:0]     spread_modulation_rate;
        logic [1:0]     spread_range;
        lducr_brt_src_t brightness_source_sel;
        logic [2:0]     slope_select;
        logic [2:0]     dither_select;
        logic           smooth_sloping_en;
        logic           rsvd0;
    } lducr_cfg_spread_t;

    // layout of the short detect register, msb first
    typedef struct packed {
        logic [6:0] rsvd15_9;
        logic       ground_short_detect_en;
        logic [3:0] rsvd7_4;
        logic       string4_short_fault_off;
        logic       string3_short_fault_off;
        logic       string2_short_fault_off;
        logic       string1_short_fault_off;
    } lducr_cfg_short_t;

    // register access request from the serial interface engine
    typedef struct packed {
        logic              wr_en;
        logic              rd_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lducr_req_t;

    // decoded steering towards the spread, sloper, dither and fault engines
    typedef struct packed {
        logic         pseudo_spread_en;
        logic [10:0]  spread_rate_hz;
        logic [6:0]   spread_range_permille;
        logic         brightness_from_reg;
        logic [31:0]  slope_cycles;
        logic         slope_enabled;
        lducr_shape_t slope_shape;
        logic [2:0]   dither_bits;
        logic         ground_short_detect_en;
        logic [3:0]   string_short_fault_en;
        logic         slope_combo_warn;
    } lducr_steer_t;

endpackage : lducr_pkg
